// ==== design/scs_clock_select.sv ====
// Contract
// - Reset selects internal oscillator as system clock
// - Internal clock divided by 1, 2, 4, 8
// - Enable and divider select internal in one write
// - External drives system clock only when select=1
// - External clock still feeds peripherals meanwhile
// - Hardware sets crystal valid once external settles
// - Missing-clock detector resets after timeout
// - Calibration register loads factory value at reset
// - RC and C modes valid without settling
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select
    import scs_pkg::*;
#(
    parameter logic [7:0] CAL_FACTORY = 8'h00
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Oscillator pins
    input  wire logic        int_osc_clk_pin,
    input  wire logic        int_osc_running_pin,
    input  wire logic        ext_osc_clk_pin,
    input  wire logic        ext_osc_settled_pin,
    // Oscillator control
    output logic             internal_osc_enable,
    output logic [7:0]       internal_osc_calibration,
    output logic [2:0]       external_osc_mode,
    output logic [2:0]       external_freq_control,
    // Clock outputs
    output logic             clock_source_select,
    output logic             system_clock_tick,
    output logic             periph_ext_clock_tick,
    // Reset and interrupt
    output logic             missing_clock_reset,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    logic int_clk_s;
    logic int_run_s;
    logic ext_clk_s;
    logic ext_set_s;

    scs_sync u_sync_int_clk (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (int_osc_clk_pin),
        .dout    (int_clk_s)
    );
    scs_sync u_sync_int_run (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (int_osc_running_pin),
        .dout    (int_run_s)
    );
    scs_sync u_sync_ext_clk (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (ext_osc_clk_pin),
        .dout    (ext_clk_s)
    );
    scs_sync u_sync_ext_set (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (ext_osc_settled_pin),
        .dout    (ext_set_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic             int_clk_prev;
    logic             ext_clk_prev;
    logic             int_tick;
    logic             ext_tick;
    logic             div_tick;
    logic [1:0]       internal_clock_divide_sel;
    logic             internal_osc_ready;
    logic             crystal_valid_flag;
    logic             ready_prev;
    logic             valid_prev;
    logic [MCD_CNT_W-1:0] mcd_count;
    logic             mcd_enable;

    // Rising edges of the sampled oscillators
    assign int_tick = internal_osc_enable & int_clk_s & ~int_clk_prev;
    assign ext_tick = (external_osc_mode != EXT_MODE_OFF) & ext_clk_s & ~ext_clk_prev;

    scs_prescaler #(
        .CNT_W (3)
    ) u_prescaler (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .tick_in  (int_tick),
        .div_sel  (internal_clock_divide_sel),
        .tick_out (div_tick)
    );

    assign internal_osc_ready = internal_osc_enable & int_run_s;

    // Valid flag per external mode
    always_comb begin
        case (external_osc_mode)
            EXT_MODE_CRYSTAL: crystal_valid_flag = ext_set_s;
            EXT_MODE_RC,
            EXT_MODE_CAP:     crystal_valid_flag = 1'b1;
            EXT_MODE_CMOS:    crystal_valid_flag = ext_set_s;
            default:          crystal_valid_flag = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    logic             next_sys_tick;
    logic             next_periph_tick;
    logic             next_mcd_reset;
    logic [MCD_CNT_W-1:0] next_mcd_count;

    always_comb begin
        next_sys_tick    = clock_source_select ? ext_tick : div_tick;
        next_periph_tick = ext_tick;
        next_mcd_reset   = 1'b0;
        next_mcd_count   = mcd_count;
        if (!mcd_enable || next_sys_tick) begin
            next_mcd_count = '0;
        end else if (mcd_count >= MCD_CNT_W'(MCD_CYCLES - 1)) begin
            next_mcd_reset = 1'b1;
            next_mcd_count = '0;
        end else begin
            next_mcd_count = mcd_count + MCD_CNT_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_clk_prev          <= 1'b0;
            ext_clk_prev          <= 1'b0;
            ready_prev            <= 1'b0;
            valid_prev            <= 1'b0;
            system_clock_tick     <= 1'b0;
            periph_ext_clock_tick <= 1'b0;
            missing_clock_reset   <= 1'b0;
            mcd_count             <= '0;
        end else begin
            int_clk_prev          <= int_clk_s;
            ext_clk_prev          <= ext_clk_s;
            ready_prev            <= internal_osc_ready;
            valid_prev            <= crystal_valid_flag;
            system_clock_tick     <= next_sys_tick;
            periph_ext_clock_tick <= next_periph_tick;
            missing_clock_reset   <= next_mcd_reset;
            mcd_count             <= next_mcd_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic             aw_held;
    logic             w_held;
    logic [7:0]       aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_event;
    logic             do_write;
    logic             do_read;

    logic             next_aw_held;
    logic             next_w_held;
    logic [7:0]       next_aw_addr;
    logic [31:0]      next_w_data;
    logic [3:0]       next_w_strb;
    logic             next_bvalid;
    logic [1:0]       next_bresp;
    logic             next_rvalid;
    logic [31:0]      next_rdata;
    logic [1:0]       next_rresp;
    logic             next_int_en;
    logic [1:0]       next_div_sel;
    logic [7:0]       next_cal;
    logic             next_clk_sel;
    logic [2:0]       next_ext_mode;
    logic [2:0]       next_ext_freq;
    logic             next_mcd_enable;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] next_irq_mask;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_write      = aw_held & w_held & ~s_axi_bvalid;
    assign do_read       = s_axi_arvalid & s_axi_arready;
    assign irq           = |(irq_status & irq_mask);

    assign irq_event[IRQ_INT_READY]   = internal_osc_ready & ~ready_prev;
    assign irq_event[IRQ_EXT_VALID]   = crystal_valid_flag & ~valid_prev;
    assign irq_event[IRQ_MISSING_CLK] = next_mcd_reset;

    always_comb begin
        next_aw_held    = aw_held;
        next_w_held     = w_held;
        next_aw_addr    = aw_addr;
        next_w_data     = w_data;
        next_w_strb     = w_strb;
        next_bvalid     = s_axi_bvalid & ~s_axi_bready;
        next_bresp      = s_axi_bresp;
        next_rvalid     = s_axi_rvalid & ~s_axi_rready;
        next_rdata      = s_axi_rdata;
        next_rresp      = s_axi_rresp;
        next_int_en     = internal_osc_enable;
        next_div_sel    = internal_clock_divide_sel;
        next_cal        = internal_osc_calibration;
        next_clk_sel    = clock_source_select;
        next_ext_mode   = external_osc_mode;
        next_ext_freq   = external_freq_control;
        next_mcd_enable = mcd_enable;
        next_irq_status = irq_status;
        next_irq_mask   = irq_mask;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            if (w_strb[0]) begin
                case (aw_addr)
                    OFS_INT_CTRL: begin
                        // Enable and divider land together
                        next_int_en  = w_data[INT_EN_BIT];
                        next_div_sel = w_data[INT_DIV_LSB +: 2];
                    end
                    OFS_INT_CAL:    next_cal        = w_data[7:0];
                    OFS_CLK_SEL:    next_clk_sel    = w_data[0];
                    OFS_EXT_CTRL: begin
                        next_ext_mode = w_data[EXT_MODE_LSB +: 3];
                        next_ext_freq = w_data[EXT_FREQ_LSB +: 3];
                    end
                    OFS_MCD_CTRL:   next_mcd_enable = w_data[0];
                    OFS_IRQ_STATUS: next_irq_status = irq_status & ~w_data[IRQ_W-1:0];
                    OFS_IRQ_MASK:   next_irq_mask   = w_data[IRQ_W-1:0];
                    default:        next_bresp      = RESP_SLVERR;
                endcase
            end
        end
        // Events set after a clear so that a set wins
        next_irq_status = next_irq_status | irq_event;
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            next_rdata  = '0;
            case (s_axi_araddr)
                OFS_INT_CTRL: begin
                    next_rdata[INT_EN_BIT]         = internal_osc_enable;
                    next_rdata[INT_RDY_BIT]        = internal_osc_ready;
                    next_rdata[INT_DIV_LSB +: 2]   = internal_clock_divide_sel;
                end
                OFS_INT_CAL:    next_rdata[7:0] = internal_osc_calibration;
                OFS_CLK_SEL:    next_rdata[0]   = clock_source_select;
                OFS_EXT_CTRL: begin
                    next_rdata[EXT_VALID_BIT]      = crystal_valid_flag;
                    next_rdata[EXT_MODE_LSB +: 3]  = external_osc_mode;
                    next_rdata[EXT_FREQ_LSB +: 3]  = external_freq_control;
                end
                OFS_MCD_CTRL:   next_rdata[0]   = mcd_enable;
                OFS_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
                OFS_IRQ_MASK:   next_rdata[IRQ_W-1:0] = irq_mask;
                default:        next_rresp      = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held                   <= 1'b0;
            w_held                    <= 1'b0;
            aw_addr                   <= 8'h00;
            w_data                    <= 32'h0000_0000;
            w_strb                    <= 4'h0;
            s_axi_bvalid              <= 1'b0;
            s_axi_bresp               <= RESP_OKAY;
            s_axi_rvalid              <= 1'b0;
            s_axi_rdata               <= 32'h0000_0000;
            s_axi_rresp               <= RESP_OKAY;
            internal_osc_enable       <= INT_CTRL_RESET[INT_EN_BIT];
            internal_clock_divide_sel <= INT_CTRL_RESET[INT_DIV_LSB +: 2];
            internal_osc_calibration  <= CAL_FACTORY;
            clock_source_select       <= 1'b0;
            external_osc_mode         <= EXT_MODE_RESET;
            external_freq_control     <= EXT_FREQ_RESET;
            mcd_enable                <= 1'b0;
            irq_status                <= '0;
            irq_mask                  <= '0;
        end else begin
            aw_held                   <= next_aw_held;
            w_held                    <= next_w_held;
            aw_addr                   <= next_aw_addr;
            w_data                    <= next_w_data;
            w_strb                    <= next_w_strb;
            s_axi_bvalid              <= next_bvalid;
            s_axi_bresp               <= next_bresp;
            s_axi_rvalid              <= next_rvalid;
            s_axi_rdata               <= next_rdata;
            s_axi_rresp               <= next_rresp;
            internal_osc_enable       <= next_int_en;
            internal_clock_divide_sel <= next_div_sel;
            internal_osc_calibration  <= next_cal;
            clock_source_select       <= next_clk_sel;
            external_osc_mode         <= next_ext_mode;
            external_freq_control     <= next_ext_freq;
            mcd_enable                <= next_mcd_enable;
            irq_status                <= next_irq_status;
            irq_mask                  <= next_irq_mask;
        end
    end

endmodule : scs_clock_select
`default_nettype wire

// ==== design/scs_pkg.sv ====
package scs_pkg;

    // Bus clock
    localparam int unsigned CLK_FREQ_KHZ        = 10000;

    // Missing-clock detector timeout, typical figure
    localparam int unsigned MCD_TIMEOUT_US      = 220;
    localparam int unsigned MCD_CYCLES          = (MCD_TIMEOUT_US * CLK_FREQ_KHZ) / 1000;
    localparam int unsigned MCD_CNT_W           = 12;

    // Register byte offsets
    localparam logic [7:0]  OFS_INT_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_INT_CAL         = 8'h04;
    localparam logic [7:0]  OFS_CLK_SEL         = 8'h08;
    localparam logic [7:0]  OFS_EXT_CTRL        = 8'h0c;
    localparam logic [7:0]  OFS_MCD_CTRL        = 8'h10;
    localparam logic [7:0]  OFS_IRQ_STATUS      = 8'h14;
    localparam logic [7:0]  OFS_IRQ_MASK        = 8'h18;

    // internal_osc_control fields
    localparam int unsigned INT_EN_BIT          = 7;
    localparam int unsigned INT_RDY_BIT         = 6;
    localparam int unsigned INT_DIV_LSB         = 0;
    localparam logic [7:0]  INT_CTRL_RESET      = 8'hc0;

    // external_osc_control fields
    localparam int unsigned EXT_VALID_BIT       = 7;
    localparam int unsigned EXT_MODE_LSB        = 4;
    localparam int unsigned EXT_FREQ_LSB        = 0;
    localparam logic [2:0]  EXT_MODE_RESET      = 3'h0;
    localparam logic [2:0]  EXT_FREQ_RESET      = 3'h0;

    // External oscillator modes
    localparam logic [2:0]  EXT_MODE_OFF        = 3'h0;
    localparam logic [2:0]  EXT_MODE_CMOS       = 3'h2;
    localparam logic [2:0]  EXT_MODE_RC         = 3'h4;
    localparam logic [2:0]  EXT_MODE_CAP        = 3'h5;
    localparam logic [2:0]  EXT_MODE_CRYSTAL    = 3'h6;

    // Interrupt status bits
    localparam int unsigned IRQ_INT_READY       = 0;
    localparam int unsigned IRQ_EXT_VALID       = 1;
    localparam int unsigned IRQ_MISSING_CLK     = 2;
    localparam int unsigned IRQ_W               = 3;

    localparam logic [1:0]  RESP_OKAY           = 2'h0;
    localparam logic [1:0]  RESP_SLVERR         = 2'h2;

endpackage : scs_pkg

// ==== design/scs_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module scs_prescaler #(
    parameter int unsigned CNT_W = 3
) (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Oscillator edge in, divided edge out
    input  wire logic       tick_in,
    input  wire logic [1:0] div_sel,
    output logic            tick_out
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] limit;

    // Divide by 1, 2, 4 or 8
    always_comb begin
        limit      = CNT_W'((1 << div_sel) - 1);
        next_count = count;
        tick_out   = 1'b0;
        if (tick_in) begin
            if (count >= limit) begin
                next_count = '0;
                tick_out   = 1'b1;
            end else begin
                next_count = count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule : scs_prescaler
`default_nettype wire

// ==== design/scs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module scs_sync (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Level
    input  wire logic din,
    output logic      dout
);
    logic stage1;
    logic next_stage1;
    logic next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end
endmodule : scs_sync
`default_nettype wire

// ==== dv/scs_clock_select_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select_chk
    import scs_pkg::*;
#(
    parameter logic [7:0] CAL_FACTORY = 8'h00
) (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Bus handshakes
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    // Clocking
    input wire logic       ext_osc_clk_pin,
    input wire logic       internal_osc_enable,
    input wire logic [7:0] internal_osc_calibration,
    input wire logic       clock_source_select,
    input wire logic       system_clock_tick,
    input wire logic       periph_ext_clock_tick,
    input wire logic       missing_clock_reset
);
    ////////////////////////////////////////
    // Cycles since the last system tick, saturating
    logic [11:0] gap;
    always_ff @(posedge aclk) begin
        if (!aresetn || system_clock_tick) gap <= 12'h000;
        else if (gap != 12'hfff) gap <= gap + 12'h001;
    end
    ////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_defaults_a: assert property (disable iff (1'b0) !aresetn |=> internal_osc_enable
        && !clock_source_select && internal_osc_calibration == CAL_FACTORY)
        else $error("reset values wrong");
    ext_drives_sys_a: assert property (clock_source_select && $past(clock_source_select)
        && periph_ext_clock_tick |-> system_clock_tick) else $error("external edge lost");
    sys_from_ext_a: assert property (clock_source_select && $past(clock_source_select)
        && system_clock_tick |-> periph_ext_clock_tick) else $error("stray system tick");
    periph_free_a: assert property ($rose(ext_osc_clk_pin) |-> ##[2:5] periph_ext_clock_tick)
        else $error("peripheral tick missing");
    mcd_gap_a: assert property (missing_clock_reset |-> gap >= MCD_CYCLES - 2)
        else $error("missing clock reset too early");
    mcd_single_a: assert property (missing_clock_reset |=> !missing_clock_reset [*8])
        else $error("missing clock reset repeated");
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    busy_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    c_mcd: cover property (missing_clock_reset);
    c_ext: cover property (clock_source_select && system_clock_tick);
    c_per: cover property (!clock_source_select && periph_ext_clock_tick);
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule : scs_clock_select_chk

bind scs_clock_select scs_clock_select_chk #(.CAL_FACTORY(CAL_FACTORY)) i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .ext_osc_clk_pin(ext_osc_clk_pin), .internal_osc_enable(internal_osc_enable),
    .internal_osc_calibration(internal_osc_calibration),
    .clock_source_select(clock_source_select), .system_clock_tick(system_clock_tick),
    .periph_ext_clock_tick(periph_ext_clock_tick), .missing_clock_reset(missing_clock_reset));
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import scs_pkg::*;
    localparam logic [7:0] CAL = 8'h5a;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, int_osc_clk_pin, int_osc_running_pin, ext_osc_clk_pin;
    logic        ext_osc_settled_pin, internal_osc_enable, clock_source_select, irq;
    logic        system_clock_tick, periph_ext_clock_tick, missing_clock_reset;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, internal_osc_calibration;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  external_osc_mode, external_freq_control;
    int          num_errors = 0, tests_run = 0, cycles = 0, sys_cnt = 0, ext_cnt = 0, n0, n1;

    scs_clock_select #(.CAL_FACTORY(CAL)) i_dut (.*);

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction : lfsr
    function automatic int div_ticks(input int edges, input logic [1:0] d);
        return edges >> d;
    endfunction : div_ticks
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d; s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        chk("bresp", er, s_axi_bresp);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        chk("rdata", exp, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic pulse(input bit ext, input int n);
        repeat (n) begin
            if (ext) ext_osc_clk_pin <= 1'b1;
            else int_osc_clk_pin <= 1'b1;
            repeat (3) @(posedge aclk);
            ext_osc_clk_pin <= 1'b0; int_osc_clk_pin <= 1'b0;
            repeat (3) @(posedge aclk);
        end
        repeat (6) @(posedge aclk);
    endtask : pulse
    ////////////////////////////////////////
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        sys_cnt <= sys_cnt + int'(system_clock_tick === 1'b1);
        ext_cnt <= ext_cnt + int'(periph_ext_clock_tick === 1'b1);
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {int_osc_clk_pin, int_osc_running_pin, ext_osc_clk_pin, ext_osc_settled_pin} = 4'h0;
        s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
        rnd = 32'h00007d5b;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("enable", 1, internal_osc_enable);
        chk("select", 0, clock_source_select);
        chk("calibration", CAL, internal_osc_calibration);
        rd(OFS_INT_CTRL, 32'h80, RESP_OKAY);
        rd(OFS_INT_CAL, {24'h0, CAL}, RESP_OKAY);
        rd(OFS_CLK_SEL, 32'h0, RESP_OKAY);
        rd(8'h1c, 32'h0, RESP_SLVERR);
        wr(8'h1c, 32'hff, RESP_SLVERR);
        for (int d = 0; d < 4; d++) begin
            wr(OFS_INT_CTRL, 32'h80 | d, RESP_OKAY);
            n0 = sys_cnt;
            pulse(1'b0, 16);
            chk("divided ticks", div_ticks(16, 2'(d)), sys_cnt - n0);
        end
        wr(OFS_EXT_CTRL, 32'h43, RESP_OKAY);
        rd(OFS_EXT_CTRL, 32'hc3, RESP_OKAY);
        chk("mode", EXT_MODE_RC, external_osc_mode);
        chk("freq", 3, external_freq_control);
        wr(OFS_CLK_SEL, 32'h1, RESP_OKAY);
        for (int s = 1; s >= 0; s--) begin
            chk("select", s, clock_source_select);
            n0 = sys_cnt;
            n1 = ext_cnt;
            pulse(1'b1, 5);
            chk("system ticks", s * 5, sys_cnt - n0);
            chk("peripheral ticks", 5, ext_cnt - n1);
            wr(OFS_CLK_SEL, 32'h0, RESP_OKAY);
        end
        wr(OFS_IRQ_STATUS, 32'h7, RESP_OKAY);
        wr(OFS_EXT_CTRL, 32'h60, RESP_OKAY);
        rd(OFS_EXT_CTRL, 32'h60, RESP_OKAY);
        ext_osc_settled_pin <= 1'b1;
        repeat (10000) @(posedge aclk);
        rd(OFS_EXT_CTRL, 32'he0, RESP_OKAY);
        rd(OFS_IRQ_STATUS, 32'h2, RESP_OKAY);
        chk("irq masked", 0, irq);
        wr(OFS_IRQ_MASK, 32'h2, RESP_OKAY);
        chk("irq raised", 1, irq);
        wr(OFS_IRQ_STATUS, 32'h2, RESP_OKAY);
        chk("irq cleared", 0, irq);
        int_osc_running_pin <= 1'b1;
        wr(OFS_INT_CTRL, 32'h00, RESP_OKAY);
        chk("enable", 0, internal_osc_enable);
        rd(OFS_INT_CTRL, 32'h00, RESP_OKAY);
        wr(OFS_INT_CTRL, 32'h80, RESP_OKAY);
        repeat (4) @(posedge aclk);
        rd(OFS_INT_CTRL, 32'hc0, RESP_OKAY);
        repeat (6) begin
            rnd = lfsr(rnd);
            wr(OFS_INT_CAL, rnd, RESP_OKAY);
            chk("calibration", rnd[7:0], internal_osc_calibration);
            rd(OFS_INT_CAL, {24'h0, rnd[7:0]}, RESP_OKAY);
        end
        wr(OFS_IRQ_MASK, 32'h4, RESP_OKAY);
        wr(OFS_MCD_CTRL, 32'h1, RESP_OKAY);
        n0 = cycles;
        while (missing_clock_reset !== 1'b1 && cycles - n0 < 3000) @(posedge aclk);
        n1 = cycles - n0;
        chk("timeout window", 1, n1 >= MCD_CYCLES - 5 && n1 <= MCD_CYCLES + 5);
        @(posedge aclk);
        chk("irq missing clock", 1, irq);
        wr(OFS_MCD_CTRL, 32'h0, RESP_OKAY);
        wr(OFS_IRQ_STATUS, 32'h4, RESP_OKAY);
        chk("irq cleared", 0, irq);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
